/* hdl/tw_regs.svh */
/*
  timing and bit-position constants of the tape word assembly datapath.
  assumes it is included by bare name from the datapath module and the checker.
*/
`ifndef TW_REGS_SVH
`define TW_REGS_SVH

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define TW_DELAY_NS 1000
`define TW_CLK_PERIOD_NS 25
`define TW_DELAY_CYC ((`TW_DELAY_NS + `TW_CLK_PERIOD_NS - 1) / `TW_CLK_PERIOD_NS)

// -----------------------------------------------------------------
// field positions and counts
// -----------------------------------------------------------------
`define TW_CTL_REQ_BIT 8
`define TW_CHARS_PER_HALF 4'h6
`define TW_HALF_RESET 18'h00000
`define TW_CHAR_RESET 6'h00

`endif

/* hdl/tw_pkg.sv */
/*
  types of the tape word assembly datapath: the pulse chain encoding.
  assumes tw_regs.svh is on the include path.
*/
package tw_pkg;

  // -----------------------------------------------------------------
  // channel timing pulse numbers, also the pending state of the chain
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {
    TW_P_NONE = 3'b000,
    TW_P_ONE = 3'b001,
    TW_P_TWO = 3'b010,
    TW_P_THREE = 3'b011,
    TW_P_FOUR = 3'b100,
    TW_P_FIVE = 3'b101,
    TW_P_SIX = 3'b110
  } tw_pulse_t;

endpackage

/* hdl/tw_datapath.sv */
/*
  data channel of a tape control: packs six-bit tape characters into
  36-bit words and unpacks them, stepped by a timed pulse chain.
  assumes the processor strobes are one-cycle pulses on core_clk_in,
  while tape strobe and mixer lines come from pins on another timebase.
*/
`timescale 1ns/1ps
`include "tw_regs.svh"

// What this block does
// - pulse five in reverse read moves staging half to output half and assembler to staging.
// - each reverse-read strobe loads six mixer bits into the assembler, rotated 1 us later.
// - after the sixth reverse-read strobe, pulses two and three rotate the assembler again.
// - reverse read with toggle set: pulse four sets the exchange flag, five clears the assembler, the next four reloads it and clears the flag.
// - pulse five with exchange flag clear issues pulse six, which flips the half-word toggle.
// - control-out with the request bit sets the request, then pulse three clears the assembler and, with toggle clear, sets word-needed;
//   data-out loads halves and drops the request, then pulse four reloads the assembler.
// - write pulse five moves the halves, resets word-needed and issues pulse six if no exchange.
// - forward write gates assembler bits 00-05 onto the mixer on pulse six and after each pulse two.
// - write pulse one after each strobe shifts the assembler left by six bits.
// - write pulse one with preamble clear loads mixer lines into bits 12-17; pulse two does not rotate the assembler.
// - the second character is presented from bits 00-05 after the first pulse two.
// - processor data-in takes the buffered word and clears the transfer request.
// - read pulse six sets the transfer request.
module tw_datapath
  import tw_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic reverse_motion_in,
  input wire logic read_function_in,
  input wire logic write_function_in,
  input wire logic write_preamble_flag_in,
  input wire logic tape_strobe_in,
  input wire logic [5:0] mixer_data_in,
  input wire logic processor_control_out_in,
  input wire logic [35:0] control_word_in,
  input wire logic processor_data_out_in,
  input wire logic [35:0] data_out_word_in,
  input wire logic processor_data_in_in,
  output logic [35:0] data_in_word_out,
  output logic [5:0] mixer_data_out,
  output logic forward_write_gate_out,
  output logic transfer_request_flag_out,
  output logic word_needed_flag_out,
  output logic half_exchange_flag_out,
  output logic half_word_toggle_out,
  output logic [2:0] channel_timing_pulse_out
);

  // -----------------------------------------------------------------
  // constants and helpers
  // -----------------------------------------------------------------
  localparam logic [7:0] DELAY_CYC = 8'(`TW_DELAY_CYC);

  // end-around rotation by one six-bit byte, bit 00 is the msb
  function automatic logic [0:17] rot6(input logic [0:17] v);
    rot6 = {v[6:17], v[0:5]};
  endfunction

  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  logic strobe_s1_q, strobe_s2_q, strobe_s3_q;
  logic [5:0] mix_s1_q, mix_s2_q;
  tw_pulse_t pulse_q, pulse_d;
  tw_pulse_t pend_q, pend_d;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] chars_q, chars_d;
  logic [0:17] sh_q, sh_d;
  logic [0:17] out_half_q, out_half_d;
  logic [0:17] stage_q, stage_d;
  logic [5:0] mix_q, mix_d;
  logic gate_q, gate_d;
  logic req_q, req_d;
  logic need_q, need_d;
  logic swap_q, swap_d;
  logic toggle_q, toggle_d;
  logic [35:0] word_q, word_d;
  logic strobe_rise;
  logic rev_read;

  assign strobe_rise = strobe_s2_q & ~strobe_s3_q;
  assign rev_read = read_function_in & reverse_motion_in;

  // -----------------------------------------------------------------
  // pin synchronisers, first stage feeds only the second
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      strobe_s3_q <= 1'b0;
      mix_s1_q <= `TW_CHAR_RESET;
      mix_s2_q <= `TW_CHAR_RESET;
    end else if (clk_en_in) begin
      strobe_s1_q <= tape_strobe_in;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
      mix_s1_q <= mixer_data_in;
      mix_s2_q <= mix_s1_q;
    end
  end

  // -----------------------------------------------------------------
  // pulse chain and datapath next values
  // -----------------------------------------------------------------
  always_comb begin
    pulse_d = TW_P_NONE;
    pend_d = pend_q;
    cnt_d = cnt_q;
    chars_d = chars_q;
    sh_d = sh_q;
    out_half_d = out_half_q;
    stage_d = stage_q;
    mix_d = mix_q;
    gate_d = gate_q & write_function_in;
    req_d = req_q;
    need_d = need_q;
    swap_d = swap_q;
    toggle_d = toggle_q;
    word_d = word_q;

    // delay line: the pending register itself costs one cycle, so fire one count early
    if (pend_q != TW_P_NONE) begin
      if (cnt_q <= 8'h01) begin
        pulse_d = pend_q;
        pend_d = TW_P_NONE;
      end else begin
        cnt_d = cnt_q - 8'h01;
      end
    end

    // a tape strobe starts a new character cycle
    if (strobe_rise && (read_function_in || write_function_in)) begin
      pulse_d = TW_P_ONE;
      pend_d = TW_P_NONE;
      chars_d = chars_q + 4'h1;
    end

    // processor side; clears come first so that sets below win
    if (processor_data_in_in) begin
      word_d = {out_half_q, stage_q};
      req_d = 1'b0;
    end
    if (processor_data_out_in) begin
      out_half_d = data_out_word_in[35:18];
      stage_d = data_out_word_in[17:0];
      req_d = 1'b0;
      if (need_q) begin
        pend_d = TW_P_FOUR;
        cnt_d = DELAY_CYC - 8'h01;
      end
    end
    if (processor_control_out_in && control_word_in[`TW_CTL_REQ_BIT] && write_function_in) begin
      req_d = 1'b1;
      pend_d = TW_P_THREE;
      cnt_d = DELAY_CYC - 8'h01;
    end

    // actions of the pulse now on the chain
    unique case (pulse_q)
      TW_P_NONE: begin
      end
      TW_P_ONE: begin
        sh_d = {sh_q[6:17], `TW_CHAR_RESET};
        if (read_function_in) begin
          sh_d[12:17] = {mix_s2_q[2:0], mix_s2_q[5:3]};
        end else if (!write_preamble_flag_in) begin
          // unusable filler while writing, overwritten on later shifts
          sh_d[12:17] = {mix_s2_q[0], mix_s2_q[1], mix_s2_q[2],
                         mix_s2_q[3], mix_s2_q[4], mix_s2_q[5]};
        end
        pend_d = TW_P_TWO;
        cnt_d = DELAY_CYC - 8'h01;
      end
      TW_P_TWO: begin
        if (rev_read) begin
          sh_d = rot6(sh_q);
        end
        if (write_function_in && !read_function_in) begin
          mix_d = sh_q[0:5];
          gate_d = 1'b1;
        end
        if (chars_q == `TW_CHARS_PER_HALF) begin
          chars_d = 4'h0;
          pend_d = TW_P_THREE;
          cnt_d = DELAY_CYC - 8'h01;
        end
      end
      TW_P_THREE: begin
        if (rev_read) begin
          sh_d = rot6(sh_q);
          pend_d = TW_P_FOUR;
          cnt_d = DELAY_CYC - 8'h01;
        end else if (read_function_in) begin
          pend_d = TW_P_FOUR;
          cnt_d = DELAY_CYC - 8'h01;
        end else begin
          sh_d = `TW_HALF_RESET;
          if (!toggle_q) begin
            need_d = 1'b1; // waits for data-out, no timeout
          end else begin
            pend_d = TW_P_FOUR;
            cnt_d = DELAY_CYC - 8'h01;
          end
        end
      end
      TW_P_FOUR: begin
        if (swap_q) begin
          sh_d = out_half_q;
          swap_d = 1'b0;
        end else if (rev_read && toggle_q) begin
          swap_d = 1'b1;
        end
        if (!read_function_in) begin
          sh_d = out_half_q;
        end
        pend_d = TW_P_FIVE;
        cnt_d = DELAY_CYC - 8'h01;
      end
      TW_P_FIVE: begin
        out_half_d = stage_q;
        stage_d = sh_q;
        if (!read_function_in) begin
          need_d = 1'b0;
        end
        if (swap_q) begin
          sh_d = `TW_HALF_RESET;
          pend_d = TW_P_FOUR;
          cnt_d = DELAY_CYC - 8'h01;
        end else begin
          pulse_d = TW_P_SIX; // next cycle, no delay
          pend_d = TW_P_NONE;
        end
      end
      TW_P_SIX: begin
        toggle_d = ~toggle_q;
        if (read_function_in) begin
          req_d = 1'b1;
        end else begin
          mix_d = sh_q[0:5];
          gate_d = 1'b1;
        end
      end
      default: begin
        pend_d = TW_P_NONE;
      end
    endcase

    // data-in in the same cycle as a pulse six must not lose the set
    if (pulse_q == TW_P_SIX && read_function_in) begin
      req_d = 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      pulse_q <= TW_P_NONE;
      pend_q <= TW_P_NONE;
      cnt_q <= 8'h00;
      chars_q <= 4'h0;
      sh_q <= `TW_HALF_RESET;
      out_half_q <= `TW_HALF_RESET;
      stage_q <= `TW_HALF_RESET;
      mix_q <= `TW_CHAR_RESET;
      gate_q <= 1'b0;
      req_q <= 1'b0;
      need_q <= 1'b0;
      swap_q <= 1'b0;
      toggle_q <= 1'b0;
      word_q <= 36'h000000000;
    end else if (clk_en_in) begin
      pulse_q <= pulse_d;
      pend_q <= pend_d;
      cnt_q <= cnt_d;
      chars_q <= chars_d;
      sh_q <= sh_d;
      out_half_q <= out_half_d;
      stage_q <= stage_d;
      mix_q <= mix_d;
      gate_q <= gate_d;
      req_q <= req_d;
      need_q <= need_d;
      swap_q <= swap_d;
      toggle_q <= toggle_d;
      word_q <= word_d;
    end
  end

  // -----------------------------------------------------------------
  // outputs, all from flip-flops
  // -----------------------------------------------------------------
  assign data_in_word_out = word_q;
  assign mixer_data_out = mix_q;
  assign forward_write_gate_out = gate_q;
  assign transfer_request_flag_out = req_q;
  assign word_needed_flag_out = need_q;
  assign half_exchange_flag_out = swap_q;
  assign half_word_toggle_out = toggle_q;
  assign channel_timing_pulse_out = pulse_q;

endmodule

/* dv/tw_datapath_checker.sv */
/*
  port checker of the tape word assembly datapath, bound to tw_datapath.
  assumes one clock domain and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "tw_regs.svh"
// -----------------------------------------------------------------
// pulse chain and flag relations
// -----------------------------------------------------------------
module tw_datapath_checker
  import tw_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic reverse_motion_in,
  input wire logic read_function_in,
  input wire logic write_function_in,
  input wire logic processor_control_out_in,
  input wire logic [35:0] control_word_in,
  input wire logic processor_data_out_in,
  input wire logic processor_data_in_in,
  input wire logic transfer_request_flag_out,
  input wire logic word_needed_flag_out,
  input wire logic half_exchange_flag_out,
  input wire logic half_word_toggle_out,
  input wire logic forward_write_gate_out,
  input wire logic [2:0] channel_timing_pulse_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  wire logic wr_only = write_function_in && !read_function_in;
  logic [2:0] p;
  assign p = channel_timing_pulse_out;

  // pulse two comes a fixed forty cycles after pulse one
  a_delay_forty_cycles: assert property (p == TW_P_TWO |-> $past(p, 40) == TW_P_ONE)
    else $error("pulse two not forty cycles after pulse one");
  a_five_then_six: assert property (p == TW_P_FIVE && !half_exchange_flag_out |=> p == TW_P_SIX)
    else $error("pulse six missing after pulse five");
  a_six_flips_toggle: assert property (p == TW_P_SIX |=> half_word_toggle_out != $past(half_word_toggle_out))
    else $error("half word toggle did not flip");
  a_exchange_flag_flips: assert property (p == TW_P_FOUR && reverse_motion_in && read_function_in
    && half_word_toggle_out |=> $changed(half_exchange_flag_out))
    else $error("exchange flag not flipped on pulse four");
  a_ctl_sets_req: assert property (processor_control_out_in && wr_only
    && control_word_in[`TW_CTL_REQ_BIT] |=> transfer_request_flag_out)
    else $error("control-out did not set request");
  a_dout_clears_req: assert property (processor_data_out_in && !processor_control_out_in
    && p != TW_P_SIX |=> !transfer_request_flag_out)
    else $error("data-out did not clear request");
  a_three_sets_need: assert property (p == TW_P_THREE && wr_only && !half_word_toggle_out
    |=> word_needed_flag_out)
    else $error("word needed not set on pulse three");
  a_five_resets_need: assert property (p == TW_P_FIVE && wr_only |=> !word_needed_flag_out)
    else $error("word needed not reset on pulse five");
  a_six_gates_char: assert property (p == TW_P_SIX && wr_only |=> forward_write_gate_out)
    else $error("write gate not raised after pulse six");
  a_read_six_req: assert property (p == TW_P_SIX && read_function_in |=> transfer_request_flag_out)
    else $error("read pulse six did not set request");
  a_din_clears_req: assert property (processor_data_in_in && !processor_control_out_in
    && p != TW_P_SIX |=> !transfer_request_flag_out)
    else $error("data-in did not clear request");
  c_read_word: cover property (p == TW_P_SIX && read_function_in);
  c_exchange: cover property ($rose(half_exchange_flag_out));
  c_write_gate: cover property ($rose(forward_write_gate_out));
endmodule

bind tw_datapath tw_datapath_checker tw_datapath_checker_i (.core_clk_in, .reset_in,
  .reverse_motion_in, .read_function_in, .write_function_in, .processor_control_out_in,
  .control_word_in, .processor_data_out_in, .processor_data_in_in, .transfer_request_flag_out,
  .word_needed_flag_out, .half_exchange_flag_out, .half_word_toggle_out,
  .forward_write_gate_out, .channel_timing_pulse_out);

/* dv/tw_tape_model.sv */
/*
  tape read/write mixer model: presents six-bit characters with a strobe.
  assumes its timing is unrelated to the core clock.
*/
`timescale 1ns/1ps
// -----------------------------------------------------------------
// character source
// -----------------------------------------------------------------
module tw_tape_model (
  output logic tape_strobe_out,
  output logic [5:0] mixer_lines_out
);
  // idle lines start on a pattern that no test expects
  initial begin
    tape_strobe_out = 1'b0;
    mixer_lines_out = 6'h15;
  end
  // data held well past the pin sync; then inverted so stale data never matches
  task automatic send_char(input logic [5:0] c);
    #7.3 mixer_lines_out = c;
    #41.9 tape_strobe_out = 1'b1;
    #150 tape_strobe_out = 1'b0;
    #150 mixer_lines_out = ~c;
  endtask
endmodule

/* dv/testbench.sv */
/*
  self-checking bench of the tape word assembly datapath.
  assumes the tape model and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
// -----------------------------------------------------------------
// reverse read then forward write, scoreboarded by queues
// -----------------------------------------------------------------
module testbench
  import tw_pkg::*;
;
  logic clk = 1'b0, rst = 1'b1, rev = 1'b0, rd = 1'b0, wr = 1'b0, en = 1'b1;
  logic ctl = 1'b0, dout = 1'b0, din = 1'b0, stb, req, need, xchg, tog, gate;
  logic [5:0] mix, wchar;
  logic [35:0] cword = 36'h0, oword = 36'h0, rword, w;
  logic [2:0] pulse;
  logic [35:0] word_q[$];
  logic [5:0] char_q[$];
  int bad_count = 0, compares = 0, seed_dummy;
  always #12.5 clk = ~clk;
  tw_datapath tw_datapath_i (.core_clk_in(clk), .reset_in(rst), .clk_en_in(en),
    .reverse_motion_in(rev), .read_function_in(rd), .write_function_in(wr),
    .write_preamble_flag_in(1'b0), .tape_strobe_in(stb), .mixer_data_in(mix),
    .processor_control_out_in(ctl), .control_word_in(cword), .processor_data_out_in(dout),
    .data_out_word_in(oword), .processor_data_in_in(din), .data_in_word_out(rword),
    .mixer_data_out(wchar), .forward_write_gate_out(gate), .transfer_request_flag_out(req),
    .word_needed_flag_out(need), .half_exchange_flag_out(xchg), .half_word_toggle_out(tog),
    .channel_timing_pulse_out(pulse));
  tw_tape_model tw_tape_model_i (.tape_strobe_out(stb), .mixer_lines_out(mix));

  task automatic give_verdict();
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic cmp_word(input logic [35:0] got, input logic [35:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_char(input logic [5:0] got, input logic [5:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // bounded wait; a hang counts against the run and ends it
  task automatic wait_pulse(input logic [2:0] p);
    for (int n = 0; pulse !== p; n++) begin
      @(negedge clk);
      if (n > 400) begin
        bad_count++;
        $display("BAD t=%0t pulse %h exp %h", $time, pulse, p);
        give_verdict();
      end
    end
  endtask
  // one-cycle processor strobe: 0 control-out, 1 data-out, 2 data-in
  task automatic cpu(input int k, input logic [35:0] v);
    @(negedge clk);
    cword = v;
    oword = v;
    ctl = (k == 0);
    dout = (k == 1);
    din = (k == 2);
    @(negedge clk);
    {ctl, dout, din} = 3'h0;
  endtask

  // word result lands one cycle after data-in
  always @(posedge clk) begin
    if (din) begin
      @(negedge clk);
      if (word_q.size() > 0) cmp_word(rword, word_q.pop_front());
    end
  end
  // written character is gated one cycle after pulse six or two; pulse read where settled
  always @(negedge clk) begin
    if (wr && (pulse == TW_P_SIX || pulse == TW_P_TWO)) begin
      @(negedge clk);
      if (char_q.size() > 0) cmp_char(wchar, char_q.pop_front());
    end
  end

  initial begin
    seed_dummy = $urandom(32'hE3793B40);
    repeat (16) @(negedge clk);
    rst = 1'b0;
    rev = 1'b1;
    rd = 1'b1;
    // all-ones half then zero half; the second is exchanged above it
    for (int h = 0; h < 2; h++) begin
      for (int c = 0; c < 6; c++) begin
        tw_tape_model_i.send_char(h ? 6'h00 : 6'h3F);
        wait_pulse(TW_P_TWO);
      end
      wait_pulse(TW_P_SIX);
    end
    word_q.push_back({18'h00000, 18'h3FFFF});
    cpu(2, 36'h0);
    $display("reverse read test done");
    {rev, rd, wr} = 3'b001;
    w = 36'({$urandom, $urandom});
    cpu(0, w | 36'h100);
    wait_pulse(TW_P_THREE);
    char_q.push_back(w[35:30]);
    char_q.push_back(w[29:24]);
    cpu(1, w);
    // freeze the chain mid-delay; the halves must survive it
    en = 1'b0;
    repeat (8) @(negedge clk);
    en = 1'b1;
    wait_pulse(TW_P_SIX);
    tw_tape_model_i.send_char(6'h2A);
    wait_pulse(TW_P_TWO);
    repeat (3) @(negedge clk);
    word_q.push_back({w[17:0], w[35:18]});
    cpu(2, 36'h0);
    repeat (3) @(negedge clk);
    $display("forward write test done");
    // a result that never appeared leaves its note behind
    if (word_q.size() != 0 || char_q.size() != 0) begin
      bad_count++;
      $display("BAD t=%0t left %h exp %h", $time, word_q.size() + char_q.size(), 0);
    end
    give_verdict();
  end
endmodule
